// ---- core/smtm_monitor.sv ----
`timescale 1ns/1ps
`include "smtm_params.svh"
module smtm_monitor #(
    parameter int CNT_W = `SMTM_CNT_W,
    parameter logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(`SMTM_TIMEOUT_CYC),
    parameter logic [CNT_W-1:0] IDLE_ABORT_CYC = CNT_W'(`SMTM_IDLE_ABORT_CYC),
    parameter logic [CNT_W-1:0] HIGH_MAX_CYC = CNT_W'(`SMTM_HIGH_MAX_CYC)
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // Bus lines, configuration and transaction start/stop
    input wire smtm_pkg::smtm_bus_s BUS_I,
    input wire smtm_pkg::smtm_rate_e RATE_I,
    input wire logic NONSTANDARD_TIMING_OPTION_I,
    input wire logic TXN_START_I,
    input wire logic TXN_STOP_I,
    // Status
    output smtm_pkg::smtm_status_s STATUS_O,
    output smtm_pkg::smtm_state_e STATE_O,
    output smtm_pkg::smtm_rate_e RATE_O
);
    import smtm_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic rate_ok(input smtm_rate_e r);
        rate_ok = (r == SMTM_RATE_STD_E) || (r == SMTM_RATE_FAST_E) || (r == SMTM_RATE_FMP_E);
    endfunction : rate_ok

    // ****************************************
    // Interval counters
    // ****************************************
    logic low_over;
    logic both_over;
    logic high_over;
    smtm_level_timer #(.W(CNT_W), .LIMIT(TIMEOUT_CYC)) u_low (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .level_i(!BUS_I.clk_line),
        .over_o(low_over)
    );
    smtm_level_timer #(.W(CNT_W), .LIMIT(IDLE_ABORT_CYC)) u_both (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .level_i(BUS_I.clk_line && BUS_I.data_line),
        .over_o(both_over)
    );
    smtm_level_timer #(.W(CNT_W), .LIMIT(HIGH_MAX_CYC)) u_high (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .level_i(BUS_I.clk_line),
        .over_o(high_over)
    );

    // ****************************************
    // Transaction state
    // ****************************************
    smtm_state_e state;
    smtm_state_e next_state;
    smtm_status_s status;
    smtm_status_s next_status;
    smtm_rate_e rate;
    smtm_rate_e next_rate;
    logic abort_ev;
    // Option bit masks the long-idle abort
    assign abort_ev = both_over && !NONSTANDARD_TIMING_OPTION_I;

    always_comb begin
        next_state = state;
        next_status = status;
        next_rate = rate;
        next_status.timeout_err = 1'b0;
        next_status.idle_abort = 1'b0;
        next_status.bus_idle = high_over;
        case (state)
            SMTM_ST_IDLE: begin
                if (rate_ok(RATE_I)) begin
                    next_rate = RATE_I;
                end
                if (TXN_START_I) begin
                    next_state = SMTM_ST_BUSY;
                end
            end
            SMTM_ST_BUSY: begin
                if (low_over) begin
                    next_state = SMTM_ST_FAULT;
                    next_status.timeout_err = 1'b1;
                    next_status.release_lines = 1'b1;
                end else if (abort_ev) begin
                    next_state = SMTM_ST_IDLE;
                    next_status.idle_abort = 1'b1;
                end else if (TXN_STOP_I) begin
                    next_state = SMTM_ST_IDLE;
                end
            end
            SMTM_ST_FAULT: begin
                if (!low_over) begin
                    next_state = SMTM_ST_IDLE;
                    next_status.release_lines = 1'b0;
                end
            end
            default: begin
                next_state = SMTM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= SMTM_ST_IDLE;
            status <= '0;
            rate <= SMTM_RATE_STD_E;
        end else begin
            state <= next_state;
            status <= next_status;
            rate <= next_rate;
        end
    end

    assign STATUS_O = status;
    assign STATE_O = state;
    assign RATE_O = rate;

    // ****************************************
    // Checks
    // ****************************************
    property p_timeout;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state == SMTM_ST_BUSY && low_over) |=> status.timeout_err && status.release_lines;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged");
    property p_abort;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state == SMTM_ST_BUSY && !low_over && abort_ev) |=> state == SMTM_ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("idle abort missed");
    property p_option;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        NONSTANDARD_TIMING_OPTION_I |=> !status.idle_abort;
    endproperty
    a_option: assert property (p_option) else $error("abort despite option");
    property p_idle;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status.bus_idle |-> $past(BUS_I.clk_line);
    endproperty
    a_idle: assert property (p_idle) else $error("idle without clock high");
    property p_rate;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        rate_ok(rate);
    endproperty
    a_rate: assert property (p_rate) else $error("bad rate");
    property p_release;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status.release_lines |-> state == SMTM_ST_FAULT;
    endproperty
    a_release: assert property (p_release) else $error("release outside fault");
    property p_rate_hold;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state != SMTM_ST_IDLE) |=> rate == $past(rate);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate changed mid transfer");
    property p_fault_hold;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state == SMTM_ST_FAULT && low_over) |=>
            state == SMTM_ST_FAULT && status.release_lines;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault left early");
    property p_fault_exit;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state == SMTM_ST_FAULT && !low_over) |=>
            state == SMTM_ST_IDLE && !status.release_lines;
    endproperty
    a_fault_exit: assert property (p_fault_exit) else $error("fault not left");
    property p_timeout_pulse;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status.timeout_err |=> !status.timeout_err;
    endproperty
    a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout too long");
    property p_idle_set;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        high_over |=> status.bus_idle;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle not flagged");
    property p_idle_clear;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !BUS_I.clk_line |=> !status.bus_idle;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle with clock low");
    property p_abort_state;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status.idle_abort |-> state == SMTM_ST_IDLE;
    endproperty
    a_abort_state: assert property (p_abort_state) else $error("abort not idle");
    property p_abort_pulse;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status.idle_abort |=> !status.idle_abort;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
    property p_option_hold;
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (state == SMTM_ST_BUSY && NONSTANDARD_TIMING_OPTION_I && !low_over && !TXN_STOP_I)
            |=> state == SMTM_ST_BUSY;
    endproperty
    a_option_hold: assert property (p_option_hold) else $error("busy dropped");

    // ****************************************
    // Cover points
    // ****************************************
    c_timeout: cover property (@(posedge CLK_SYS_I) status.timeout_err);
    c_abort: cover property (@(posedge CLK_SYS_I) status.idle_abort);
    c_stop: cover property (@(posedge CLK_SYS_I) state == SMTM_ST_BUSY ##1 state == SMTM_ST_IDLE);
    c_option: cover property (@(posedge CLK_SYS_I)
        state == SMTM_ST_BUSY && NONSTANDARD_TIMING_OPTION_I);
endmodule : smtm_monitor

// ---- core/smtm_params.svh ----
`ifndef SMTM_PARAMS_SVH
`define SMTM_PARAMS_SVH
// ****************************************
// Timing figures
// ****************************************
`define SMTM_CLK_HZ 200000000
`define SMTM_TIMEOUT_MS 35
`define SMTM_IDLE_ABORT_MS 50
`define SMTM_HIGH_MAX_US 50
`define SMTM_STRETCH_MS 25
`define SMTM_TIMEOUT_CYC ((`SMTM_CLK_HZ / 1000) * `SMTM_TIMEOUT_MS)
`define SMTM_IDLE_ABORT_CYC ((`SMTM_CLK_HZ / 1000) * `SMTM_IDLE_ABORT_MS)
`define SMTM_HIGH_MAX_CYC ((`SMTM_CLK_HZ / 1000000) * `SMTM_HIGH_MAX_US)
`define SMTM_STRETCH_CYC ((`SMTM_CLK_HZ / 1000) * `SMTM_STRETCH_MS)
// ****************************************
// Bus rate codes and counter width
// ****************************************
`define SMTM_RATE_STD 2'h0
`define SMTM_RATE_FAST 2'h1
`define SMTM_RATE_FMP 2'h2
`define SMTM_CNT_W 24
`endif

// ---- core/smtm_pkg.sv ----
package smtm_pkg;
    typedef enum logic [1:0] {
        SMTM_RATE_STD_E = 2'h0,
        SMTM_RATE_FAST_E = 2'h1,
        SMTM_RATE_FMP_E = 2'h2
    } smtm_rate_e;
    typedef enum logic [1:0] {
        SMTM_ST_IDLE = 2'h0,
        SMTM_ST_BUSY = 2'h1,
        SMTM_ST_FAULT = 2'h2
    } smtm_state_e;
    typedef struct packed {
        logic clk_line;
        logic data_line;
    } smtm_bus_s;
    typedef struct packed {
        logic timeout_err;
        logic idle_abort;
        logic bus_idle;
        logic release_lines;
    } smtm_status_s;
endpackage : smtm_pkg

// ---- core/smtm_level_timer.sv ----
`timescale 1ns/1ps
// Counts cycles a level holds; restarts when it drops
module smtm_level_timer #(
    parameter int W = 24,
    parameter logic [W-1:0] LIMIT = 24'h0000ff
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic over_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (!level_i) begin
            next_cnt = '0;
        end else if (cnt != LIMIT) begin
            next_cnt = cnt + W'(1);
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign over_o = level_i && (cnt == LIMIT);
endmodule : smtm_level_timer

// ---- test/smtm_bus_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Far-side bus party
// ****************************************
module smtm_bus_model (
    input wire logic clk_i,
    input wire logic [1:0] mode_i,
    output smtm_pkg::smtm_bus_s bus_o
);
    import smtm_pkg::*;
    logic ph = 1'b0;
    always @(posedge clk_i) begin
        ph <= ~ph;
    end
    always_comb begin
        case (mode_i)
            2'h1: bus_o = '{clk_line: ph, data_line: ~ph};
            2'h2: bus_o = '{clk_line: 1'b0, data_line: ph};
            default: bus_o = '{clk_line: 1'b1, data_line: 1'b1};
        endcase
    end
endmodule : smtm_bus_model

// ---- test/smtm_monitor_test.sv ----
`timescale 1ns/1ps
module smtm_monitor_test;
    import smtm_pkg::*;
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic opt = 1'b0;
    logic start = 1'b0;
    logic stop = 1'b0;
    smtm_rate_e rate = SMTM_RATE_STD_E;
    smtm_bus_s bus;
    smtm_status_s st;
    smtm_state_e state;
    smtm_rate_e rate_o;
    int checks = 0;
    int n_mismatch = 0;
    int cyc = 0;
    int n;
    initial forever #2.5 clk = ~clk;
    smtm_bus_model i_far (.clk_i(clk), .mode_i(mode), .bus_o(bus));
    smtm_monitor #(.TIMEOUT_CYC(24'h000014), .IDLE_ABORT_CYC(24'h000028),
        .HIGH_MAX_CYC(24'h00000a)) i_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
        .BUS_I(bus), .RATE_I(rate), .NONSTANDARD_TIMING_OPTION_I(opt),
        .TXN_START_I(start), .TXN_STOP_I(stop), .STATUS_O(st), .STATE_O(state),
        .RATE_O(rate_o));
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic txn(input logic go, input logic [1:0] m);
        @(posedge clk);
        start <= go;
        stop <= ~go;
        mode <= m;
        @(posedge clk);
        start <= 1'b0;
        stop <= 1'b0;
        #1;
    endtask : txn
    task automatic wait_ev(input logic tmo);
        n = 1;
        while (n < 60 && !(tmo ? st.timeout_err === 1'b1 : st.idle_abort === 1'b1)) begin
            tick(1);
            n++;
        end
    endtask : wait_ev
    task automatic test_rates;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            rate <= smtm_rate_e'(r);
            tick(2);
            `CHK("rate", (r == 3) ? SMTM_RATE_FMP_E : smtm_rate_e'(r), rate_o)
        end
        $display("rates done");
    endtask : test_rates
    task automatic test_timeout;
        txn(1'b1, 2'h2);
        wait_ev(1'b1);
        `CHK("timeout_cycles", 1'b1, n >= 20 && n <= 23)
        tick(1);
        `CHK("fault", SMTM_ST_FAULT, state)
        `CHK("release", 1'b1, st.release_lines)
        mode <= 2'h0;
        tick(3);
        `CHK("recover", SMTM_ST_IDLE, state)
        `CHK("release_off", 1'b0, st.release_lines)
        $display("timeout done");
    endtask : test_timeout
    task automatic test_abort;
        // Toggle first so the both-high count starts with the transfer
        mode <= 2'h1;
        tick(4);
        txn(1'b1, 2'h0);
        wait_ev(1'b0);
        `CHK("abort_cycles", 1'b1, n >= 39 && n <= 43)
        tick(2);
        `CHK("abort_idle", SMTM_ST_IDLE, state)
        `CHK("bus_idle", 1'b1, st.bus_idle)
        $display("abort done");
    endtask : test_abort
    task automatic test_option;
        opt <= 1'b1;
        txn(1'b1, 2'h0);
        tick(60);
        `CHK("no_abort", SMTM_ST_BUSY, state)
        txn(1'b0, 2'h0);
        tick(2);
        `CHK("stop_idle", SMTM_ST_IDLE, state)
        opt <= 1'b0;
        $display("option done");
    endtask : test_option
    task automatic test_restart;
        txn(1'b1, 2'h2);
        tick(15);
        mode <= 2'h1;
        tick(3);
        mode <= 2'h2;
        tick(15);
        mode <= 2'h1;
        tick(2);
        `CHK("restart", SMTM_ST_BUSY, state)
        `CHK("bus_busy", 1'b0, st.bus_idle)
        txn(1'b0, 2'h0);
        $display("restart done");
    endtask : test_restart
    task automatic test_reset;
        txn(1'b1, 2'h0);
        @(posedge clk);
        rst_n <= 1'b0;
        tick(3);
        `CHK("rst_state", SMTM_ST_IDLE, state)
        `CHK("rst_status", 4'h0, st)
        `CHK("rst_rate", SMTM_RATE_STD_E, rate_o)
        @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        `CHK("rst_rate_kept", SMTM_RATE_STD_E, rate_o)
        `CHK("rst_idle_state", SMTM_ST_IDLE, state)
        $display("reset done");
    endtask : test_reset
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(2);
        test_rates();
        test_timeout();
        test_abort();
        test_option();
        test_restart();
        test_reset();
        conclude();
    end
endmodule : smtm_monitor_test
